// [core/spi_flash_read_command_decoder.sv]
`timescale 1ns/1ps
`include "spi_dec_params.svh"
// How it works
// - opcode always takes 8 clocks, single lane
// - address takes 24, 12 or 6 clocks
// - mode byte takes 4 or 2 clocks
// - data byte takes 8, 4 or 2 clocks
// - 05h/35h return one status byte, single lane
// - 01h/31h write one status byte, single lane
// - 5Ah: address, 8 wait clocks, parameter stream
// - 92h dual ID after 4 waits; 90h single
// - 94h quad address, 4 waits, quad ID
// - 4Bh: 32 waits, then unique-ID stream
// - read address counter advances by itself
// - data shifts out MSB first after address
// - 07FFFFh wraps to 000000h without delay
// - chip select release floats serial output
// - release mid-byte is accepted without error
// - dual: high bit on SO, low on SI
// - dual: one byte every four clocks
// - release in dual read floats both pins
// - MSB first, framed by chip select
// - bad opcode ignored until next frame
// - address bits 23..19 are dropped
module spi_flash_read_command_decoder #(
   parameter logic [7:0] MFR_ID = 8'h11,  // arbitrary value
   parameter logic [7:0] DEV_ID = 8'h22,  // arbitrary value
   parameter int         DEPTH  = 2
) (
   // system
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // link pins, io[0] is SI and io[1] is SO
   input  wire logic                 cs_n,
   input  wire logic                 sclk,
   input  wire logic [3:0]           io_in,
   output logic      [3:0]           io_out,
   output logic      [3:0]           io_oe,
   // byte feeder
   output logic                      fetch_start,
   output logic      [18:0]          fetch_addr,
   output spi_dec_pkg::space_t       fetch_space,
   input  wire logic                 src_valid,
   input  wire logic [7:0]           src_data,
   output logic                      src_ready,
   // status and events
   output logic      [18:0]          cur_addr,
   output logic      [7:0]           sr1,
   output logic      [7:0]           sr2,
   output logic                      suspend_req,
   output logic                      resume_req,
   output logic                      underrun
);
   import spi_dec_pkg::*;

   logic [1:0]  rst_sync_reg;      // reset release
   logic        rst_int_n;
   logic [1:0]  cs_s_reg;          // pin synchronisers
   logic [2:0]  sclk_s_reg;        // third stage for edges
   logic [3:0]  io_s0_reg;
   logic [3:0]  io_s1_reg;
   logic        cs_act;
   logic        rise;
   logic        fall;
   state_t      state_reg;
   cmd_t        cmd_reg;
   cmd_t        dec;               // decode of incoming opcode
   logic [5:0]  cnt_reg;           // clocks into phase
   logic [5:0]  phase_len;
   logic        last;              // final clock of phase
   logic [2:0]  in_lanes;
   logic [23:0] in_sh_reg;
   logic [23:0] in_next;
   logic [7:0]  out_sh_reg;
   logic [2:0]  out_cnt_reg;       // clocks left in byte
   logic [1:0]  byte_cnt_reg;      // bytes sent, saturating
   logic        load;              // start of a byte out
   logic        stop_dout;         // byte limit reached
   logic [7:0]  tx_byte;
   logic [18:0] rd_addr_reg;
   logic        pop;
   logic        fetch_start_reg;
   logic [18:0] fetch_addr_reg;
   logic [7:0]  sr1_reg;
   logic [7:0]  sr2_reg;
   logic        suspend_reg;
   logic        resume_reg;
   logic        underrun_reg;
   logic [3:0]  io_out_reg;
   logic [3:0]  io_oe_reg;

   byte_stream_if #(.WIDTH(8)) bs ();

   two_entry_buffer #(.WIDTH(8), .DEPTH(DEPTH)) u_buf (
      .clk       (clk),
      .rst_int_n (rst_int_n),
      .bs        (bs.buf_side)
   );

   // clocks of a field carried on a lane count
   function automatic logic [5:0] clks(input logic [5:0] bits, input logic [2:0] lanes);
      case (lanes)
         3'h2:    clks = {1'b0, bits[5:1]};
         3'h4:    clks = {2'b00, bits[5:2]};
         default: clks = bits;
      endcase
   endfunction : clks

   // phase_lane_format table
   function automatic cmd_t cmd_decode(input logic [7:0] op);
      cmd_t c;
      c = '0;
      c.addr_lanes = 3'h1;
      c.data_lanes = 3'h1;
      c.ok = 1'b1;
      case (op)
         `OP_READ:    begin c.has_addr = 1'b1; c.src = SRC_STREAM; end
         `OP_FAST:    begin c.has_addr = 1'b1; c.src = SRC_STREAM; c.wait_clks = `WAIT_FAST; end
         `OP_DUAL:    begin c.has_addr = 1'b1; c.src = SRC_STREAM; c.wait_clks = `WAIT_FAST;
                            c.data_lanes = 3'h2; end
         `OP_RDSR1:   begin c.src = SRC_SR1; c.max_bytes = `SR_BYTES; end
         `OP_RDSR2:   begin c.src = SRC_SR2; c.max_bytes = `SR_BYTES; end
         `OP_WRSR1:   begin c.src = SRC_SR1; c.data_in = 1'b1; end
         `OP_WRSR2:   begin c.src = SRC_SR2; c.data_in = 1'b1; end
         `OP_ID1:     begin c.has_addr = 1'b1; c.src = SRC_ID; c.max_bytes = `ID_BYTES; end
         `OP_ID2:     begin c.has_addr = 1'b1; c.src = SRC_ID; c.max_bytes = `ID_BYTES;
                            c.addr_lanes = 3'h2; c.data_lanes = 3'h2; c.wait_clks = `WAIT_ID; end
         `OP_ID4:     begin c.has_addr = 1'b1; c.src = SRC_ID; c.max_bytes = `ID_BYTES;
                            c.addr_lanes = 3'h4; c.data_lanes = 3'h4; c.wait_clks = `WAIT_ID; end
         `OP_SFDP:    begin c.has_addr = 1'b1; c.src = SRC_STREAM; c.space = SPACE_SFDP;
                            c.wait_clks = `WAIT_FAST; end
         `OP_UID:     begin c.src = SRC_STREAM; c.space = SPACE_UID;
                            c.wait_clks = `WAIT_UID; end
         `OP_SUSPEND: c.suspend = 1'b1;
         `OP_RESUME:  c.resume = 1'b1;
         default:     c.ok = 1'b0;
      endcase
      return c;
   endfunction : cmd_decode

   // async assert, synchronous release
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rst_sync_reg <= 2'h0;
      else
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end
   assign rst_int_n = rst_sync_reg[1];

   // pins cross in through two flops; sclk must stay below clk / 8
   always_ff @(posedge clk or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         cs_s_reg   <= 2'h3;
         sclk_s_reg <= 3'h0;
         io_s0_reg  <= 4'h0;
         io_s1_reg  <= 4'h0;
      end
      else
      begin
         cs_s_reg   <= {cs_s_reg[0], cs_n};
         sclk_s_reg <= {sclk_s_reg[1:0], sclk};
         io_s0_reg  <= io_in;
         io_s1_reg  <= io_s0_reg;
      end
   end
   assign cs_act = !cs_s_reg[1];
   assign rise   = sclk_s_reg[1] && !sclk_s_reg[2];
   assign fall   = !sclk_s_reg[1] && sclk_s_reg[2];

   // input shift, MSB first, lanes gathered high to low
   assign in_lanes = (state_reg == ST_ADDR) ? cmd_reg.addr_lanes : 3'h1;
   always_comb
   begin
      case (in_lanes)
         3'h2:    in_next = {in_sh_reg[21:0], io_s1_reg[1], io_s1_reg[0]};
         3'h4:    in_next = {in_sh_reg[19:0], io_s1_reg[3:0]};
         default: in_next = {in_sh_reg[22:0], io_s1_reg[0]};
      endcase
   end

   // length of the current phase in link clocks
   always_comb
   begin
      case (state_reg)
         ST_OPCODE: phase_len = clks(`OPC_BITS, 3'h1);
         ST_ADDR:   phase_len = clks(cmd_reg.has_mode ? `ADDR_BITS + `MODE_BITS
                                                      : `ADDR_BITS, cmd_reg.addr_lanes);
         ST_WAIT:   phase_len = cmd_reg.wait_clks;
         default:   phase_len = clks(`BYTE_BITS, 3'h1);
      endcase
   end
   assign dec  = cmd_decode(in_next[7:0]);
   assign last = rise && (cnt_reg == 6'(phase_len - 6'h1));

   // byte out starts on a falling edge once the previous one is spent
   assign load      = fall && (state_reg == ST_DOUT) && (out_cnt_reg == 3'h0);
   assign stop_dout = load && (cmd_reg.max_bytes != 2'h0) && (byte_cnt_reg == cmd_reg.max_bytes);
   assign pop       = load && !stop_dout && (cmd_reg.src == SRC_STREAM) && bs.drain_valid;
   always_comb
   begin
      case (cmd_reg.src)
         SRC_SR1:    tx_byte = sr1_reg;
         SRC_SR2:    tx_byte = sr2_reg;
         SRC_ID:     tx_byte = (byte_cnt_reg == 2'h0) ? MFR_ID : DEV_ID;
         default:    tx_byte = bs.drain_valid ? bs.drain_data : 8'hff;
      endcase
   end

   // phase sequencer; frame end overrides everything
   always_ff @(posedge clk or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         state_reg       <= ST_IDLE;
         cmd_reg         <= '0;
         cnt_reg         <= 6'h0;
         in_sh_reg       <= 24'h0;
         fetch_start_reg <= 1'b0;
         fetch_addr_reg  <= 19'h0;
         suspend_reg     <= 1'b0;
         resume_reg      <= 1'b0;
      end
      else
      begin
         fetch_start_reg <= 1'b0;
         suspend_reg     <= 1'b0;
         resume_reg      <= 1'b0;
         if (!cs_act)
         begin
            state_reg <= ST_IDLE;
         end
         else if (state_reg == ST_IDLE)
         begin
            state_reg <= ST_OPCODE;
            cnt_reg   <= 6'h0;
         end
         else if (stop_dout)
         begin
            state_reg <= ST_IGNORE;
         end
         else if (rise && state_reg != ST_DOUT && state_reg != ST_IGNORE)
         begin
            in_sh_reg <= in_next;
            cnt_reg   <= last ? 6'h0 : 6'(cnt_reg + 6'h1);
            if (last)
            begin
               case (state_reg)
                  ST_OPCODE:
                  begin
                     cmd_reg     <= dec;
                     suspend_reg <= dec.suspend;
                     resume_reg  <= dec.resume;
                     if (!dec.ok || dec.suspend || dec.resume)
                        state_reg <= ST_IGNORE;
                     else if (dec.has_addr)
                        state_reg <= ST_ADDR;
                     else
                     begin
                        fetch_start_reg <= (dec.src == SRC_STREAM);
                        fetch_addr_reg  <= 19'h0;
                        state_reg <= (dec.wait_clks != 6'h0) ? ST_WAIT
                                   : (dec.data_in ? ST_DIN : ST_DOUT);
                     end
                  end
                  ST_ADDR:
                  begin
                     fetch_start_reg <= (cmd_reg.src == SRC_STREAM);
                     fetch_addr_reg  <= in_next[18:0];
                     state_reg <= (cmd_reg.wait_clks != 6'h0) ? ST_WAIT : ST_DOUT;
                  end
                  ST_WAIT:  state_reg <= ST_DOUT;
                  ST_DIN:   state_reg <= ST_IGNORE;
                  default:  state_reg <= ST_IGNORE;
               endcase
            end
         end
      end
   end

   // status registers written by 01h / 31h
   always_ff @(posedge clk or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         sr1_reg <= `SR_RESET;
         sr2_reg <= `SR_RESET;
      end
      else if (cs_act && state_reg == ST_DIN && last)
      begin
         if (cmd_reg.src == SRC_SR1)
            sr1_reg <= in_next[7:0];
         else
            sr2_reg <= in_next[7:0];
      end
   end

   // serial output shifter, MSB on the highest driven lane
   always_ff @(posedge clk or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         out_sh_reg   <= 8'h0;
         out_cnt_reg  <= 3'h0;
         byte_cnt_reg <= 2'h0;
         io_out_reg   <= 4'h0;
         io_oe_reg    <= 4'h0;
         underrun_reg <= 1'b0;
      end
      else if (!cs_act || state_reg != ST_DOUT || stop_dout)
      begin
         io_oe_reg    <= 4'h0;
         out_cnt_reg  <= 3'h0;
         byte_cnt_reg <= cs_act ? byte_cnt_reg : 2'h0;
      end
      else if (load)
      begin
         byte_cnt_reg <= (byte_cnt_reg == 2'h3) ? 2'h3 : 2'(byte_cnt_reg + 2'h1);
         underrun_reg <= underrun_reg | ((cmd_reg.src == SRC_STREAM) && !bs.drain_valid);
         out_cnt_reg  <= 3'(clks(`BYTE_BITS, cmd_reg.data_lanes) - 6'h1);
         case (cmd_reg.data_lanes)
            3'h2:
            begin
               io_out_reg <= {2'b00, tx_byte[7], tx_byte[6]};
               io_oe_reg  <= 4'h3;
               out_sh_reg <= {tx_byte[5:0], 2'b00};
            end
            3'h4:
            begin
               io_out_reg <= tx_byte[7:4];
               io_oe_reg  <= 4'hf;
               out_sh_reg <= {tx_byte[3:0], 4'h0};
            end
            default:
            begin
               io_out_reg <= {2'b00, tx_byte[7], 1'b0};
               io_oe_reg  <= 4'h2;
               out_sh_reg <= {tx_byte[6:0], 1'b0};
            end
         endcase
      end
      else if (fall)
      begin
         out_cnt_reg <= 3'(out_cnt_reg - 3'h1);
         case (cmd_reg.data_lanes)
            3'h2:    io_out_reg <= {2'b00, out_sh_reg[7], out_sh_reg[6]};
            3'h4:    io_out_reg <= out_sh_reg[7:4];
            default: io_out_reg <= {2'b00, out_sh_reg[7], 1'b0};
         endcase
         out_sh_reg <= (cmd_reg.data_lanes == 3'h4) ? {out_sh_reg[3:0], 4'h0}
                     : (cmd_reg.data_lanes == 3'h2) ? {out_sh_reg[5:0], 2'b00}
                     : {out_sh_reg[6:0], 1'b0};
      end
   end

   // running read address, loaded at start, wraps at array end
   always_ff @(posedge clk or negedge rst_int_n)
   begin
      if (!rst_int_n)
         rd_addr_reg <= 19'h0;
      else if (fetch_start_reg)
         rd_addr_reg <= fetch_addr_reg;
      else if (pop)
         rd_addr_reg <= (rd_addr_reg == `ARRAY_LAST) ? 19'h0 : 19'(rd_addr_reg + 19'h1);
   end

   // buffer hookup; a new fetch or frame end discards stale bytes
   assign bs.fill_valid  = src_valid;
   assign bs.fill_data   = src_data;
   assign bs.drain_ready = pop;
   assign bs.flush       = !cs_act || fetch_start_reg;
   assign src_ready      = bs.fill_ready;

   assign io_out      = io_out_reg;
   assign io_oe       = io_oe_reg;
   assign fetch_start = fetch_start_reg;
   assign fetch_addr  = fetch_addr_reg;
   assign fetch_space = cmd_reg.space;
   assign cur_addr    = rd_addr_reg;
   assign sr1         = sr1_reg;
   assign sr2         = sr2_reg;
   assign suspend_req = suspend_reg;
   assign resume_req  = resume_reg;
   assign underrun    = underrun_reg;

   // checks
   AST_OPC_LEN: assert property (@(posedge clk) disable iff (!rst_int_n)
      (cs_act && state_reg == ST_OPCODE && rise && cnt_reg < 6'h7) |=> state_reg == ST_OPCODE)
      else $error("opcode phase ended early");
   AST_ADDR_LEN: assert property (@(posedge clk) disable iff (!rst_int_n)
      (cs_act && state_reg == ST_ADDR && rise && cnt_reg == 6'(clks(`ADDR_BITS,
       cmd_reg.addr_lanes) - 6'h1)) |=> state_reg != ST_ADDR)
      else $error("address phase length wrong");
   AST_HIZ_RELEASE: assert property (@(posedge clk) disable iff (!rst_int_n)
      $rose(cs_s_reg[1]) |=> ##1 io_oe == 4'h0)
      else $error("output still driven after release");
   AST_DUAL_HIZ: assert property (@(posedge clk) disable iff (!rst_int_n)
      (!cs_act && cmd_reg.data_lanes == 3'h2) |=> io_oe[1:0] == 2'b00)
      else $error("dual pins still driven");
   AST_DUAL_PINS: assert property (@(posedge clk) disable iff (!rst_int_n)
      (load && !stop_dout && cs_act && cmd_reg.data_lanes == 3'h2)
      |=> io_out[1:0] == $past(tx_byte[7:6]) && io_oe == 4'h3)
      else $error("dual bit placement wrong");
   AST_WRAP: assert property (@(posedge clk) disable iff (!rst_int_n)
      (pop && !fetch_start_reg && rd_addr_reg == `ARRAY_LAST) |=> rd_addr_reg == 19'h0)
      else $error("no wrap at array end");
   AST_ADDR_STEP: assert property (@(posedge clk) disable iff (!rst_int_n)
      (pop && !fetch_start_reg && rd_addr_reg != `ARRAY_LAST)
      |=> rd_addr_reg == 19'($past(rd_addr_reg) + 19'h1))
      else $error("address counter did not advance");
   AST_IGNORE_HOLD: assert property (@(posedge clk) disable iff (!rst_int_n)
      (state_reg == ST_IGNORE && cs_act) |=> (state_reg == ST_IGNORE || !cs_act) && io_oe == 4'h0)
      else $error("left ignore state inside frame");
   AST_SR_WRITE: assert property (@(posedge clk) disable iff (!rst_int_n)
      (cs_act && state_reg == ST_DIN && last && cmd_reg.src == SRC_SR1)
      |=> sr1_reg == $past(in_next[7:0]) ##1 state_reg != ST_DIN)
      else $error("status write lost");
   AST_SUSPEND: assert property (@(posedge clk) disable iff (!rst_int_n)
      suspend_req |-> state_reg == ST_IGNORE && !fetch_start_reg)
      else $error("suspend not opcode-only");
endmodule : spi_flash_read_command_decoder

// [core/spi_dec_params.svh]
`ifndef SPI_DEC_PARAMS_SVH
`define SPI_DEC_PARAMS_SVH

// opcodes served by the decoder
`define OP_READ      8'h03
`define OP_FAST      8'h0b
`define OP_DUAL      8'h3b
`define OP_RDSR1     8'h05
`define OP_RDSR2     8'h35
`define OP_WRSR1     8'h01
`define OP_WRSR2     8'h31
`define OP_ID1       8'h90
`define OP_ID2       8'h92
`define OP_ID4       8'h94
`define OP_SFDP      8'h5a
`define OP_UID       8'h4b
`define OP_SUSPEND   8'h75
`define OP_RESUME    8'h7a

// field widths in bits, phase clocks follow from bits / lanes
`define OPC_BITS     6'h08
`define ADDR_BITS    6'h18
`define MODE_BITS    6'h08
`define BYTE_BITS    6'h08

// wait clocks per command
`define WAIT_FAST    6'h08
`define WAIT_ID      6'h04
`define WAIT_UID     6'h20

// byte limits and array end
`define ID_BYTES     2'h2
`define SR_BYTES     2'h1
`define ARRAY_LAST   19'h7ffff
`define SR_RESET     8'h00

`endif

// [core/spi_dec_pkg.sv]
package spi_dec_pkg;
   // decoder phases
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_OPCODE = 3'b001,
      ST_ADDR   = 3'b010,
      ST_WAIT   = 3'b011,
      ST_DIN    = 3'b100,
      ST_DOUT   = 3'b101,
      ST_IGNORE = 3'b110
   } state_t;
   // where outgoing bytes come from
   typedef enum logic [1:0] {
      SRC_SR1    = 2'b00,
      SRC_SR2    = 2'b01,
      SRC_ID     = 2'b10,
      SRC_STREAM = 2'b11
   } src_t;
   // address space asked of the byte feeder
   typedef enum logic [1:0] {
      SPACE_ARRAY = 2'b00,
      SPACE_SFDP  = 2'b01,
      SPACE_UID   = 2'b10
   } space_t;
   // phase_lane_format of one command
   typedef struct packed {
      logic       ok;
      logic       has_addr;
      logic       has_mode;
      logic [2:0] addr_lanes;
      logic [5:0] wait_clks;
      logic [2:0] data_lanes;
      logic       data_in;
      src_t       src;
      space_t     space;
      logic [1:0] max_bytes;
      logic       suspend;
      logic       resume;
   } cmd_t;
endpackage : spi_dec_pkg

// [core/byte_stream_if.sv]
`timescale 1ns/1ps
interface byte_stream_if #(parameter int WIDTH = 8);
   logic             fill_valid;   // feeder offers a word
   logic             fill_ready;   // buffer has room
   logic [WIDTH-1:0] fill_data;
   logic             drain_valid;  // buffer holds a word
   logic             drain_ready;  // shifter takes it
   logic [WIDTH-1:0] drain_data;
   logic             flush;        // drop everything held
   modport buf_side  (input fill_valid, fill_data, drain_ready, flush,
                      output fill_ready, drain_valid, drain_data);
   modport core_side (output fill_valid, fill_data, drain_ready, flush,
                      input fill_ready, drain_valid, drain_data);
endinterface : byte_stream_if

// [core/two_entry_buffer.sv]
`timescale 1ns/1ps
module two_entry_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   // system
   input wire logic         clk,
   input wire logic         rst_int_n,
   // both sides
   byte_stream_if.buf_side  bs
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_reg [DEPTH];  // storage
   logic [PW-1:0]    wr_ptr_reg;       // next slot to fill
   logic [PW-1:0]    rd_ptr_reg;       // oldest word
   logic [CW-1:0]    count_reg;        // words held
   logic             push;
   logic             pop;

   // honest flags: full stalls the feeder, empty leaves the shifter sending ffh
   assign bs.fill_ready  = (count_reg != CW'(DEPTH));
   assign bs.drain_valid = (count_reg != '0);
   assign bs.drain_data  = mem_reg[rd_ptr_reg];
   assign push = bs.fill_valid && bs.fill_ready && !bs.flush;
   assign pop  = bs.drain_valid && bs.drain_ready && !bs.flush;

   // pointer step with wrap for any depth
   function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
      step = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction : step

   // storage write, no reset needed on data
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem_reg[wr_ptr_reg] <= bs.fill_data;
      end
   end

   // pointers and occupancy; flush wins over traffic
   always_ff @(posedge clk or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end
      else if (bs.flush)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_reg <= step(wr_ptr_reg);
         end
         if (pop)
         begin
            rd_ptr_reg <= step(rd_ptr_reg);
         end
         if (push && !pop)
         begin
            count_reg <= CW'(count_reg + 1'b1);
         end
         else if (pop && !push)
         begin
            count_reg <= CW'(count_reg - 1'b1);
         end
      end
   end
endmodule : two_entry_buffer

// [test/host_model.sv]
`timescale 1ns/1ps
module host_model (
   // system
   input  wire logic       clk,
   // link pins
   output logic            cs_n,
   output logic            sclk,
   output logic      [3:0] io_in,
   input  wire logic [3:0] io_out,
   input  wire logic [3:0] io_oe
);
   logic [3:0]  hval;    // host lane values
   logic [3:0]  hen;     // host lane enables
   logic        tog;     // junk for released lanes
   logic [31:0] q;       // bits read off the resolved lanes at rises
   logic        oe_seen; // device drove at some rise
   // wire resolution: device lanes loop back, released lanes never hold old value
   assign io_in = (io_oe & io_out) | (~io_oe & ((hen & hval) | (~hen & {4{tog}})));
   // idle link: cs high, clock parked low (mode 0)
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b0;
      hen = 4'h0;
      hval = 4'h0;
      tog = 1'b0;
   end
   // open a frame, 8 clk before the first rise
   task open_f();
      oe_seen = 1'b0;
      @(posedge clk) #1 cs_n = 1'b0;
      repeat (3) @(posedge clk);
      #1 hen = 4'h0;  // lanes only ever change off the clock edge
   endtask : open_f
   // close a frame, gap well over 3 clk before the next
   task close_f();
      hen = 4'h0;
      repeat (3) @(posedge clk);
      #1 cs_n = 1'b1;
      repeat (8) @(posedge clk);
   endtask : close_f
   // n link clocks on l lanes, msb first; 5 clk low then 5 clk high
   task xf(input int n, input int l, input logic [31:0] d, input bit drv);
      logic [3:0] m;
      m = 4'((1 << l) - 1);
      q = 32'h0;
      for (int i = 0; i < n; i++)
      begin
         tog = ~tog;
         hen = drv ? m : 4'h0;
         hval = 4'(d >> ((n - 1 - i) * l));
         repeat (5) @(posedge clk);
         #1 sclk = 1'b1;
         q = (q << l) | 32'(l == 1 ? {3'h0, io_in[1]} : io_in & m);
         oe_seen = oe_seen | (|io_oe);
         repeat (5) @(posedge clk);
         #1 sclk = 1'b0;
      end
   endtask : xf
endmodule : host_model

// [test/test_spi_flash_read_command_decoder.sv]
`timescale 1ns/1ps
module test_spi_flash_read_command_decoder;
   import spi_dec_pkg::*;
   // one command: opcode, address, addr lanes, waits, data lanes, bytes, expected
   typedef struct {logic [7:0] op; logic [23:0] a; int al; int w; int dl; int n;
                   logic [23:0] e;} row_t;
   logic clk, rst_n, cs_n, sclk, fetch_start, src_valid, src_ready;
   logic suspend_req, resume_req, underrun, held_reg;
   logic [3:0] io_in, io_out, io_oe;
   logic [18:0] fetch_addr, cur_addr, ptr_reg;
   logic [7:0] src_data, sr1, sr2;
   space_t fetch_space;
   int bad_count, samples_checked, cyc, sus_count, res_count;
   // feeder pattern is a[7:0]+a[18:11], so wrap and id bytes stand apart
   row_t rows [10] = '{'{8'h03, 24'hf7fffe, 1, 0, 1, 3, 24'hfdfe00},
      '{8'h0b, 24'h10, 1, 8, 1, 2, 24'h1011}, '{8'h3b, 24'h7ffff, 1, 8, 2, 2, 24'hfe00},
      '{8'h05, 0, 0, 0, 1, 1, 0}, '{8'h35, 0, 0, 0, 1, 1, 0},
      '{8'h90, 0, 1, 0, 1, 2, 24'h1122}, '{8'h92, 0, 2, 4, 2, 2, 24'h1122},
      '{8'h94, 0, 4, 4, 4, 2, 24'h1122}, '{8'h5a, 24'h800, 1, 8, 1, 1, 24'h01},
      '{8'h4b, 0, 0, 32, 1, 2, 24'h0001}};
   spi_flash_read_command_decoder u_dut (.clk, .rst_n, .cs_n, .sclk, .io_in, .io_out,
      .io_oe, .fetch_start, .fetch_addr, .fetch_space, .src_valid, .src_data,
      .src_ready, .cur_addr, .sr1, .sr2, .suspend_req, .resume_req, .underrun);
   host_model u_host (.clk, .cs_n, .sclk, .io_in, .io_out, .io_oe);
   // feeder gaps one cycle in four, but never withdraws a word not yet taken
   assign src_valid = !fetch_start && (held_reg || cyc[1:0] != 2'h0);
   assign src_data = ptr_reg[7:0] + ptr_reg[18:11];
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         ptr_reg <= 19'h0;
         held_reg <= 1'b0;
         sus_count <= 0;
         res_count <= 0;
      end
      else
      begin
         ptr_reg <= fetch_start ? fetch_addr : ptr_reg + 19'(src_valid && src_ready);
         sus_count <= sus_count + int'(suspend_req);
         res_count <= res_count + int'(resume_req);
         held_reg <= src_valid && !src_ready;
      end
   task chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task finish_test();
      if (bad_count == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   // clock and hang guard
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;  // nba, so feeder and buffer agree on each edge
      if (cyc == 40000)
      begin
         bad_count++;
         finish_test();
      end
   end
   initial
   begin
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (5) @(posedge clk);
      chk({io_oe, sr1, sr2}, 0);
      foreach (rows[i])
      begin
         u_host.open_f();
         u_host.xf(8, 1, rows[i].op, 1'b1);
         if (rows[i].al != 0) u_host.xf(24 / rows[i].al, rows[i].al, rows[i].a, 1'b1);
         if (rows[i].w != 0) u_host.xf(rows[i].w, 1, 0, 1'b0);
         u_host.xf(rows[i].n * 8 / rows[i].dl, rows[i].dl, 0, 1'b0);
         chk(u_host.q, 32'(rows[i].e));
         chk(u_host.oe_seen, 1);
         u_host.close_f();
         chk(io_oe, 0);
      end
      // status writes, then read back
      u_host.open_f();
      u_host.xf(16, 1, 16'h01a5, 1'b1);
      u_host.close_f();
      u_host.open_f();
      u_host.xf(16, 1, 16'h313c, 1'b1);
      u_host.close_f();
      chk({sr1, sr2}, 16'ha53c);
      // abort mid-byte, unknown opcode, then suspend and resume
      u_host.open_f();
      u_host.xf(32, 1, 32'h030000f0, 1'b1);
      u_host.xf(3, 1, 0, 1'b0);
      chk(u_host.q, 32'h7);
      u_host.close_f();
      chk(io_oe, 0);
      u_host.open_f();
      u_host.xf(24, 1, 24'h9f0000, 1'b1);
      chk(u_host.oe_seen, 0);
      u_host.close_f();
      u_host.open_f();
      u_host.xf(8, 1, 8'h05, 1'b1);
      u_host.xf(8, 1, 0, 1'b0);
      chk(u_host.q, 8'ha5);
      u_host.close_f();
      u_host.open_f();
      u_host.xf(8, 1, 8'h75, 1'b1);
      u_host.close_f();
      u_host.open_f();
      u_host.xf(8, 1, 8'h7a, 1'b1);
      u_host.close_f();
      chk({sus_count[3:0], res_count[3:0], 3'h0, underrun}, 12'h110);
      finish_test();
   end
endmodule : test_spi_flash_read_command_decoder
